//--- core/dpi_pkg.sv
// package with register map, command codes and timing constants
package dpi_pkg;
	// apb register byte offsets
	localparam logic [7:0] DPI_OFS_CTRL = 8'h00;
	localparam logic [7:0] DPI_OFS_STAT = 8'h04;
	localparam logic [7:0] DPI_OFS_MR = 8'h08;
	localparam logic [7:0] DPI_OFS_EMR1 = 8'h0C;
	localparam logic [7:0] DPI_OFS_EMR2 = 8'h10;
	localparam logic [7:0] DPI_OFS_EMR3 = 8'h14;
	localparam logic [7:0] DPI_OFS_STEP = 8'h18;
	// control field positions
	localparam int DPI_CTRL_START = 0;
	localparam int DPI_CTRL_OCD_SKIP = 1;
	// status field positions
	localparam int DPI_STAT_BUSY = 0;
	localparam int DPI_STAT_DONE = 1;
	// reset values of the mode images and the control register
	localparam logic [13:0] DPI_MR_RST = 14'h0_000;
	localparam logic [13:0] DPI_EMR_RST = 14'h0_000;
	localparam logic [31:0] DPI_CTRL_RST = 32'h0000_0000;
	// address bit positions that carry meaning in the sequence
	localparam int DPI_A_DLL_DIS = 0;
	localparam int DPI_A_DLL_RST = 8;
	localparam int DPI_A_PRE_ALL = 10;
	localparam int DPI_A_OCD_LO = 7;
	localparam int DPI_A_TOP = 13;
	// command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] DPI_CMD_NOP = 4'h7;
	localparam logic [3:0] DPI_CMD_DESEL = 4'hF;
	localparam logic [3:0] DPI_CMD_PRE = 4'h2;
	localparam logic [3:0] DPI_CMD_REF = 4'h1;
	localparam logic [3:0] DPI_CMD_MRS = 4'h0;
	// bank codes of the mode registers
	localparam logic [2:0] DPI_BA_MR = 3'h0;
	localparam logic [2:0] DPI_BA_EMR1 = 3'h1;
	localparam logic [2:0] DPI_BA_EMR2 = 3'h2;
	localparam logic [2:0] DPI_BA_EMR3 = 3'h3;
	// timing
	localparam int DPI_CLK_PS = 4000;
	localparam int DPI_T_STABLE_US = 200;
	localparam int DPI_T_CKE_NS = 400;
	localparam int DPI_T_OCD_CLK = 200;
	localparam int DPI_T_MRD_CLK = 2;
	localparam int DPI_T_RP_NS = 15;
	localparam int DPI_T_RFC_NS = 128;
	localparam int DPI_N_REF = 2;
	// ceiling division of a time in ps by the clock period
	function automatic int dpi_cyc(input int t_ps);
		dpi_cyc = (t_ps + DPI_CLK_PS - 1) / DPI_CLK_PS;
		if (dpi_cyc < 1) begin
			dpi_cyc = 1;
		end
	endfunction
	localparam int DPI_STABLE_CYC = dpi_cyc(DPI_T_STABLE_US * 1000 * 1000);
	localparam int DPI_CKE_CYC = dpi_cyc(DPI_T_CKE_NS * 1000);
	localparam int DPI_RP_CYC = dpi_cyc(DPI_T_RP_NS * 1000);
	localparam int DPI_RFC_CYC = dpi_cyc(DPI_T_RFC_NS * 1000);
endpackage

//--- core/dpi_wait.sv
// down counter timing the gap after each issued command
`timescale 1ns/1ps
module dpi_wait #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// load request with the wait length
	input wire logic load,
	input wire logic [W-1:0] len,
	// high once the wait has run out
	output logic idle
);
	logic [W-1:0] cnt_q; // cycles still to wait

	// load, then count to zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= len;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// registered idle flag, valid one cycle after load
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			idle <= 1'b1;
		end else begin
			idle <= !load && (cnt_q <= 1);
		end
	end
endmodule

//--- core/dpi_ctrl.sv
// ddr2 power-up initialisation controller with apb register port
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module dpi_ctrl
	import dpi_pkg::*;
#(
	parameter int STABLE_CYC = DPI_STABLE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// memory pins
	output logic mem_cke,
	output logic mem_odt,
	output logic mem_cs_n,
	output logic mem_ras_n,
	output logic mem_cas_n,
	output logic mem_we_n,
	output logic [2:0] mem_ba,
	output logic [13:0] mem_addr
);
	import dpi_pkg::*;

	typedef enum {
		ST_IDLE, ST_STABLE, ST_CKE, ST_PRE1, ST_EMR2, ST_EMR3,
		ST_EMR1, ST_DLLRST, ST_PRE2, ST_REF, ST_MR, ST_OCDWAIT,
		ST_OCDDEF, ST_OCDEXIT, ST_DONE
	} dpi_st_t;

	dpi_st_t st_q; // sequencer state
	logic [13:0] mr_q, emr1_q, emr2_q, emr3_q; // software mode images
	logic start_q; // start request, cleared when taken
	logic ocd_skip_q; // run default/exit pair instead of stopping
	logic done_q; // sequence finished
	logic [1:0] ref_q; // refreshes issued
	logic [7:0] ocd_cnt_q; // clocks since dll reset
	logic [23:0] stable_q; // clock stable counter
	logic [7:0] cke_age_q; // clocks since cke went high, saturating
	logic wt_load; // start a post-command wait
	logic [15:0] wt_len; // length of that wait
	logic wt_idle; // wait finished
	logic busy; // sequence running
	logic acc; // apb access phase

	assign busy = (st_q != ST_IDLE) && (st_q != ST_DONE);
	assign acc = psel && penable;

	// gap timer between commands
	dpi_wait #(.W(16)) u_wait (
		.clk_sys(clk_sys),
		.srst(srst),
		.load(wt_load),
		.len(wt_len),
		.idle(wt_idle)
	);

	// issue a command: drives pins for one cycle
	function automatic logic [20:0] cmd(input logic [3:0] c,
		input logic [2:0] ba, input logic [13:0] a);
		cmd = {c, ba, a};
	endfunction

	// apb: zero wait state, unmapped offsets raise pslverr
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
				DPI_OFS_CTRL: prdata <= {30'h0, ocd_skip_q, start_q};
				DPI_OFS_STAT: prdata <= {30'h0, done_q, busy};
				DPI_OFS_MR: prdata <= {18'h0, mr_q};
				DPI_OFS_EMR1: prdata <= {18'h0, emr1_q};
				DPI_OFS_EMR2: prdata <= {18'h0, emr2_q};
				DPI_OFS_EMR3: prdata <= {18'h0, emr3_q};
				DPI_OFS_STEP: prdata <= {28'h0, 4'(st_q)};
				default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// software registers; images change only while idle or done
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			start_q <= 1'b0;
			ocd_skip_q <= DPI_CTRL_RST[DPI_CTRL_OCD_SKIP];
			mr_q <= DPI_MR_RST;
			emr1_q <= DPI_EMR_RST;
			emr2_q <= DPI_EMR_RST;
			emr3_q <= DPI_EMR_RST;
		end else begin
			if (st_q == ST_STABLE) begin
				start_q <= 1'b0;
			end
			if (acc && pready && pwrite && !busy) begin
				case (paddr)
				DPI_OFS_CTRL: begin
					start_q <= pwdata[DPI_CTRL_START];
					ocd_skip_q <= pwdata[DPI_CTRL_OCD_SKIP];
				end
				DPI_OFS_MR: mr_q <= pwdata[13:0];
				DPI_OFS_EMR1: emr1_q <= pwdata[13:0];
				DPI_OFS_EMR2: emr2_q <= pwdata[13:0];
				DPI_OFS_EMR3: emr3_q <= pwdata[13:0];
				default: ;
				endcase
			end
		end
	end

	// clock stable, dll-reset age and cke age counters
	always_ff @(posedge clk_sys) begin
		if (srst || st_q == ST_IDLE) begin
			stable_q <= '0;
		end else if (st_q == ST_STABLE) begin
			stable_q <= stable_q + 1'b1;
		end
		if (srst || st_q == ST_DLLRST) begin
			ocd_cnt_q <= '0;
		end else if (ocd_cnt_q != 8'hFF) begin
			ocd_cnt_q <= ocd_cnt_q + 1'b1;
		end
		if (srst || !mem_cke) begin
			cke_age_q <= '0;
		end else if (cke_age_q != 8'hFF) begin
			cke_age_q <= cke_age_q + 1'b1;
		end
	end

	// sequencer and pin drive
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_q <= ST_IDLE;
			mem_cke <= 1'b0;
			mem_odt <= 1'b0;
			{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr}
				<= cmd(DPI_CMD_DESEL, 3'h0, 14'h0);
			ref_q <= '0;
			done_q <= 1'b0;
			wt_load <= 1'b0;
			wt_len <= '0;
		end else begin
			wt_load <= 1'b0;
			// default to nop between commands
			{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr}
				<= cmd(DPI_CMD_NOP, 3'h0, 14'h0);
			mem_odt <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				if (start_q) begin
					st_q <= ST_STABLE;
					done_q <= 1'b0;
					mem_cke <= 1'b0;
				end
			end
			ST_STABLE: begin
				if (stable_q >= 24'(STABLE_CYC)) begin
					mem_cke <= 1'b1;
					wt_load <= 1'b1;
					wt_len <= 16'(DPI_CKE_CYC);
					st_q <= ST_CKE;
				end
			end
			ST_CKE: begin
				if (wt_idle && !wt_load) begin
					{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
						mem_addr} <= cmd(DPI_CMD_PRE, 3'h0,
						14'(1 << DPI_A_PRE_ALL));
					wt_load <= 1'b1;
					wt_len <= 16'(DPI_RP_CYC);
					st_q <= ST_PRE1;
				end
			end
			ST_PRE1, ST_EMR2, ST_EMR3, ST_EMR1, ST_DLLRST, ST_PRE2,
			ST_REF, ST_MR, ST_OCDWAIT, ST_OCDDEF, ST_OCDEXIT: begin
				if (wt_idle && !wt_load) begin
					wt_load <= 1'b1;
					wt_len <= 16'(DPI_T_MRD_CLK);
					case (st_q)
					ST_PRE1: begin
						{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
							mem_addr} <= cmd(DPI_CMD_MRS, DPI_BA_EMR2,
							emr2_q);
						st_q <= ST_EMR2;
					end
					ST_EMR2: begin
						{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
							mem_addr} <= cmd(DPI_CMD_MRS, DPI_BA_EMR3,
							emr3_q);
						st_q <= ST_EMR3;
					end
					ST_EMR3: begin
						// dll on, ocd field cleared, top bit low
						{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
							mem_addr} <= cmd(DPI_CMD_MRS, DPI_BA_EMR1,
							emr1_q & 14'h1C7E);
						st_q <= ST_EMR1;
					end
					ST_EMR1: begin
						{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
							mem_addr} <= cmd(DPI_CMD_MRS, DPI_BA_MR,
							(mr_q & 14'h1FFF) | 14'h0100);
						st_q <= ST_DLLRST;
					end
					ST_DLLRST: begin
						{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
							mem_addr} <= cmd(DPI_CMD_PRE, 3'h0,
							14'(1 << DPI_A_PRE_ALL));
						wt_len <= 16'(DPI_RP_CYC);
						ref_q <= '0;
						st_q <= ST_PRE2;
					end
					ST_PRE2, ST_REF: begin
						if (ref_q < 2'(DPI_N_REF)) begin
							{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
								mem_addr} <= cmd(DPI_CMD_REF, 3'h0,
								14'h0);
							wt_len <= 16'(DPI_RFC_CYC);
							ref_q <= ref_q + 1'b1;
							st_q <= ST_REF;
						end else begin
							{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
								mem_addr} <= cmd(DPI_CMD_MRS, DPI_BA_MR,
								mr_q & 14'h1EFF);
							st_q <= ST_MR;
						end
					end
					ST_MR: begin
						wt_load <= 1'b0;
						st_q <= ocd_skip_q ? ST_OCDWAIT : ST_DONE;
					end
					ST_OCDWAIT: begin
						wt_load <= 1'b0;
						if (ocd_cnt_q >= 8'(DPI_T_OCD_CLK)) begin
							wt_load <= 1'b1;
							{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
								mem_addr} <= cmd(DPI_CMD_MRS, DPI_BA_EMR1,
								(emr1_q & 14'h1C7E) | 14'h0380);
							st_q <= ST_OCDDEF;
						end
					end
					ST_OCDDEF: begin
						{mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba,
							mem_addr} <= cmd(DPI_CMD_MRS, DPI_BA_EMR1,
							emr1_q & 14'h1C7E);
						st_q <= ST_OCDEXIT;
					end
					default: begin
						wt_load <= 1'b0;
						st_q <= ST_DONE;
					end
					endcase
				end
			end
			ST_DONE: begin
				done_q <= 1'b1;
				if (start_q) begin
					st_q <= ST_IDLE; // re-init keeps array data
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// assertions
	a_odt_low: assert property (@(posedge clk_sys)
		disable iff (srst) mem_odt == 1'b0) else $error("odt driven high");
	a_cke_stable: assert property (@(posedge clk_sys)
		disable iff (srst) $rose(mem_cke) |-> $past(st_q) == ST_STABLE
		&& $past(stable_q) >= 24'(STABLE_CYC))
		else $error("cke rose early");
	a_cke_nop: assert property (@(posedge clk_sys)
		disable iff (srst) $rose(mem_cke) |-> mem_ras_n && mem_cas_n
		&& mem_we_n && !mem_cs_n) else $error("cke rose without nop");
	a_cke_gap: assert property (@(posedge clk_sys)
		disable iff (srst) !mem_cs_n && !(mem_ras_n && mem_cas_n
		&& mem_we_n) |-> cke_age_q >= 8'(DPI_CKE_CYC))
		else $error("command too soon after cke");
	a_emr2_ba: assert property (@(posedge clk_sys)
		disable iff (srst) $rose(st_q == ST_EMR2) |-> mem_ba == DPI_BA_EMR2)
		else $error("emr2 bank wrong");
	a_emr3_ba: assert property (@(posedge clk_sys)
		disable iff (srst) $rose(st_q == ST_EMR3) |-> mem_ba == DPI_BA_EMR3)
		else $error("emr3 bank wrong");
	a_dll_en: assert property (@(posedge clk_sys)
		disable iff (srst) $rose(st_q == ST_EMR1) |-> mem_addr[0] == 1'b0
		&& mem_addr[9:7] == 3'h0 && mem_addr[13] == 1'b0)
		else $error("dll enable bits wrong");
	a_dll_rst: assert property (@(posedge clk_sys)
		disable iff (srst) $rose(st_q == ST_DLLRST) |-> mem_addr[8]
		&& mem_ba == 3'h0) else $error("dll reset bit missing");
	a_mr_final: assert property (@(posedge clk_sys)
		disable iff (srst) $rose(st_q == ST_MR) |-> !mem_addr[8]
		&& ref_q == 2'(DPI_N_REF)) else $error("final mrs wrong");
	a_mode_gap: assert property (@(posedge clk_sys)
		disable iff (srst) !mem_cs_n && !mem_ras_n && !mem_cas_n |=>
		mem_ras_n && mem_cas_n && mem_we_n) else $error("tmrd violated");
	c_done: cover property (@(posedge clk_sys) $rose(done_q));
	c_ocd: cover property (@(posedge clk_sys) st_q == ST_OCDEXIT);
	c_reinit: cover property (@(posedge clk_sys)
		st_q == ST_DONE ##1 st_q == ST_IDLE);
endmodule

//--- test/dpi_mem_model.sv
// behavioural memory that stores mode registers and checks init order
`timescale 1ns/1ps
module dpi_mem_model
	import dpi_pkg::*;
(
	// clock, reset and run control from the bench
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic restart,
	input wire logic ocd,
	// memory pins as driven by the controller
	input wire logic mem_cke,
	input wire logic mem_odt,
	input wire logic mem_cs_n,
	input wire logic mem_ras_n,
	input wire logic mem_cas_n,
	input wire logic mem_we_n,
	input wire logic [2:0] mem_ba,
	input wire logic [13:0] mem_addr,
	// stored mode registers and counts
	output logic [13:0] mr_q,
	output logic [13:0] emr1_q,
	output logic [13:0] emr2_q,
	output logic [13:0] emr3_q,
	output int cmd_n,
	output int fault_cnt
);
	logic [3:0] cmd; // chip select is part of the code
	logic [13:0] a; // short alias of the address pins
	logic mrs; // any mode register write
	logic act; // a selected command other than nop
	logic ok; // the command matches the next step
	logic kept; // emr1 fields outside a9..a7 unchanged
	int gap; // cycles since the last command
	int cke_cyc; // cycles since cke rose
	int dll_cyc; // cycles since the dll reset
	assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
	assign a = mem_addr;
	assign mrs = (cmd == DPI_CMD_MRS);
	assign act = (mem_cs_n == 1'b0) && (cmd != DPI_CMD_NOP);
	assign kept = (a & ~14'h0380) == (emr1_q & ~14'h0380);
	// expected command of each step
	always_comb begin
		case (cmd_n)
			0, 5: ok = cmd == DPI_CMD_PRE && a[DPI_A_PRE_ALL]
				&& cke_cyc >= DPI_CKE_CYC;
			1: ok = mrs && mem_ba == DPI_BA_EMR2;
			2: ok = mrs && mem_ba == DPI_BA_EMR3;
			3: ok = mrs && mem_ba == DPI_BA_EMR1 && !a[0]
				&& a[9:7] == 3'h0 && !a[13];
			4: ok = mrs && mem_ba == DPI_BA_MR && a[8] && !a[13];
			6, 7: ok = cmd == DPI_CMD_REF;
			8: ok = mrs && mem_ba == DPI_BA_MR && !a[8];
			9: ok = ocd && mrs && mem_ba == DPI_BA_EMR1 && a[9:7] == 3'h7
				&& kept && dll_cyc >= DPI_T_OCD_CLK;
			10: ok = ocd && mrs && mem_ba == DPI_BA_EMR1
				&& a[9:7] == 3'h0 && kept;
			default: ok = 1'b0;
		endcase
	end
	// cycle counters for the minimum spacings
	always_ff @(posedge clk_sys) begin
		cke_cyc <= (mem_cke && !srst) ? cke_cyc + 1 : 0;
		gap <= (srst || restart) ? 99 : (act ? 1 : gap + 1);
		dll_cyc <= (act && cmd_n == 4) ? 1 : dll_cyc + 1;
	end
	// step counter, restarted for every run
	always_ff @(posedge clk_sys) begin
		if (srst || restart) begin
			cmd_n <= 0;
		end else if (act) begin
			cmd_n <= cmd_n + 1;
		end
	end
	// fault count: odt, order, cke and tmrd spacing
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fault_cnt <= 0;
		end else if (mem_odt !== 1'b0) begin
			fault_cnt <= fault_cnt + 1;
		end else if (act && (!ok || !mem_cke || gap < DPI_T_MRD_CLK)) begin
			fault_cnt <= fault_cnt + 1;
		end
	end
	// mode writes replace the whole register, nothing else is touched
	always_ff @(posedge clk_sys) begin
		if (mrs) begin
			case (mem_ba)
				DPI_BA_MR: mr_q <= a;
				DPI_BA_EMR1: emr1_q <= a;
				DPI_BA_EMR2: emr2_q <= a;
				default: emr3_q <= a;
			endcase
		end
	end
endmodule

//--- test/dpi_ctrl_test.sv
// self-checking bench: apb tasks drive the init controller
`timescale 1ns/1ps
`define CHK(x, y) begin \
	comparisons++; \
	if ((x) !== (y)) begin \
		error_cnt++; \
		$display("wrong value t=%0t got %0h exp %0h", $time, x, y); \
	end \
end
module dpi_ctrl_test;
	import dpi_pkg::*;
	localparam int STAB = 20; // shortened clock settle time
	localparam logic [13:0] MRV = 14'h0632; // a8 low image
	localparam logic [13:0] E1V = 14'h2385; // sets bits the init clears
	localparam logic [13:0] E2V = 14'h0080;
	localparam logic [13:0] E3V = 14'h0000;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic restart = 1'b0;
	logic ocd = 1'b0;
	logic [31:0] prdata, q;
	logic pready, pslverr, e;
	logic mem_cke, mem_odt, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
	logic [2:0] mem_ba;
	logic [13:0] mem_addr, mr_q, emr1_q, emr2_q, emr3_q;
	int cmd_n, fault_cnt;
	int error_cnt = 0;
	int comparisons = 0;
	// design under test with a short settle count
	dpi_ctrl #(.STABLE_CYC(STAB)) i_dpi_ctrl (.clk_sys(clk_sys),
		.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_cke(mem_cke), .mem_odt(mem_odt),
		.mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
		.mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr));
	// memory model on the far side
	dpi_mem_model i_dpi_mem_model (.clk_sys(clk_sys), .srst(srst),
		.restart(restart), .ocd(ocd), .mem_cke(mem_cke), .mem_odt(mem_odt),
		.mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
		.mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
		.mr_q(mr_q), .emr1_q(emr1_q), .emr2_q(emr2_q), .emr3_q(emr3_q),
		.cmd_n(cmd_n), .fault_cnt(fault_cnt));
	// 250 mhz clock
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	// counts, verdict and end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// a hung wait counts as a mismatch
	task automatic timeout();
		error_cnt++;
		$display("wrong value t=%0t wait ran out", $time);
		final_report();
	endtask
	// one apb transfer: setup, access until pready, release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) timeout();
		@(posedge clk_sys);
	endtask
	// one init run, then the stored images and the step count
	task automatic run(input logic [31:0] ctl, input int ncmd, input bit first);
		int n;
		restart <= 1'b1;
		ocd <= ctl[DPI_CTRL_OCD_SKIP];
		@(posedge clk_sys);
		restart <= 1'b0;
		apb(1'b1, DPI_OFS_CTRL, ctl);
		// a re-init first drops cke; wait for that before looking for the rise
		for (n = 0; n < 20 && mem_cke === 1'b1; n++) @(posedge clk_sys);
		if (n == 20) timeout();
		for (n = 0; n < 2000 && mem_cke !== 1'b1; n++) @(posedge clk_sys);
		if (n == 2000) timeout();
		if (first) `CHK(n >= STAB - 1, 1'b1)
		apb(1'b0, DPI_OFS_STAT, 32'h0000_0000);
		`CHK(q[DPI_STAT_BUSY], 1'b1)
		apb(1'b1, DPI_OFS_MR, 32'h0000_1111); // dropped while busy
		for (n = 0; n < 400; n++) begin
			apb(1'b0, DPI_OFS_STAT, 32'h0000_0000);
			if (q[DPI_STAT_DONE] === 1'b1) break;
		end
		if (n == 400) timeout();
		`CHK(q[DPI_STAT_BUSY], 1'b0)
		`CHK(cmd_n, ncmd)
		`CHK(fault_cnt, 0)
		`CHK(mr_q, MRV)
		`CHK(emr1_q, E1V & ~14'h2381)
		`CHK(emr2_q, E2V)
		`CHK(emr3_q, E3V)
		`CHK(mem_cke, 1'b1)
		apb(1'b0, DPI_OFS_MR, 32'h0000_0000);
		`CHK(q[13:0], MRV)
		$display("test init ctl=%0h ended", ctl);
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		`CHK(mem_cke, 1'b0)
		`CHK(mem_odt, 1'b0)
		`CHK(mem_cs_n, 1'b1)
		apb(1'b0, DPI_OFS_CTRL, 32'h0000_0000);
		`CHK(q, DPI_CTRL_RST)
		apb(1'b0, DPI_OFS_EMR1, 32'h0000_0000);
		`CHK(q[13:0], DPI_EMR_RST)
		apb(1'b0, 8'h1C, 32'h0000_0000);
		`CHK(e, 1'b1)
		apb(1'b1, DPI_OFS_MR, {18'h0_0000, MRV});
		apb(1'b1, DPI_OFS_EMR1, {18'h0_0000, E1V});
		apb(1'b1, DPI_OFS_EMR2, {18'h0_0000, E2V});
		apb(1'b1, DPI_OFS_EMR3, {18'h0_0000, E3V});
		apb(1'b0, DPI_OFS_EMR1, 32'h0000_0000);
		`CHK(q[13:0], E1V)
		`CHK(e, 1'b0)
		$display("test registers ended");
		run(32'h0000_0001, 9, 1'b1);
		run(32'h0000_0003, 11, 1'b0);
		final_report();
	end
endmodule
